// *** design/setpoint_pkg.sv ***
// Constants shared by the setpoint, ramp and heater range logic
package setpoint_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 125000;
    // Ramp update tick period in milliseconds
    localparam int unsigned TICK_MS = 60;
    localparam int unsigned TICK_CYCLES = TICK_MS * CLK_KHZ;
    // Setpoint button hold time for ramp bypass
    localparam int unsigned HOLD_MS = 3000;
    localparam int unsigned HOLD_TICKS = HOLD_MS / TICK_MS;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned NUM_OUT = 2;
    localparam int unsigned SP_W = 32;
    localparam int unsigned RATE_W = 10;
    localparam int unsigned PCT_W = 16;
    localparam int unsigned CNT_W = 24;
    localparam int unsigned HOLD_W = 7;

    // ------------------------------------------------------------
    // Values and reset values
    // ------------------------------------------------------------
    // Setpoint in units of 0.0001 K, reset to 0.0000 K
    localparam logic [31:0] SP_RESET = 32'h0000_0000;
    // Ramp rate in 0.1 per minute: 0 to 100.0
    localparam logic [9:0] RATE_MAX = 10'h3E8;
    // Output percentage in 0.01 %: 100.00 %
    localparam logic [15:0] PCT_MAX = 16'h2710;
    // Power decade between adjacent current ranges
    localparam int unsigned RANGE_DECADE = 10;

    // ------------------------------------------------------------
    // Heater range codes
    // ------------------------------------------------------------
    localparam logic [1:0] RANGE_OFF = 2'h0;
    localparam logic [1:0] RANGE_LOW = 2'h1;
    localparam logic [1:0] RANGE_MED = 2'h2;
    localparam logic [1:0] RANGE_HIGH = 2'h3;
    // Single setting of the voltage output
    localparam logic [1:0] RANGE_ON = 2'h1;
    // Index of the output that may run in voltage mode
    localparam int unsigned VOLT_OUT = 1;

endpackage

// *** design/setpoint_ramp_heater_range.sv ***
// Setpoint entry, ramp generator and heater range control
`timescale 1ns/100ps
`default_nettype none

module setpoint_ramp_heater_range #(
    parameter int unsigned TICK_CYCLES = setpoint_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control loop configuration per output
    input wire logic [1:0] loop_valid,
    input wire logic [1:0] pref_temp,
    input wire logic [1:0] open_loop,
    input wire logic volt_mode,
    // Limits per output
    input wire logic [1:0][31:0] curve_limit,
    input wire logic [1:0][31:0] sensor_lo,
    input wire logic [1:0][31:0] sensor_hi,
    // Setpoint entry
    input wire logic [1:0] setpoint_command,
    input wire logic [1:0][31:0] setpoint_value,
    // Curve conversion of the present setpoint into the other units
    input wire logic [1:0][31:0] conv_setpoint,
    // Present measured temperature of each control input
    input wire logic [1:0][31:0] meas_temp,
    // Ramp control
    input wire logic [1:0] ramp_en,
    input wire logic [1:0][9:0] ramp_rate,
    input wire logic [1:0] stop_ramp,
    // Front panel setpoint button and the loop it addresses
    input wire logic sp_button,
    input wire logic disp_sel,
    // Heater range entry
    input wire logic [1:0] range_wr,
    input wire logic [1:0][1:0] range_value,
    input wire logic all_off,
    // Shutdown causes
    input wire logic temp_limit,
    input wire logic [1:0] setup_change,
    input wire logic power_loss_off,
    input wire logic [1:0] input_error,
    // Output computation
    input wire logic [1:0] manual_output_command,
    input wire logic [1:0][15:0] manual_value,
    input wire logic [1:0][15:0] pid_result,
    // Results
    output logic [1:0][31:0] active_setpoint,
    output logic [1:0][31:0] ramp_target,
    output logic [1:0] ramping,
    output logic [1:0][1:0] heater_range,
    output logic [1:0][15:0] drive,
    output logic [1:0] setpoint_command_refused
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << setpoint_pkg::CNT_W))
    begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end

    if (setpoint_pkg::HOLD_TICKS < 1 ||
        setpoint_pkg::HOLD_TICKS > (1 << setpoint_pkg::HOLD_W))
    begin : g_bad_hold
        $error("HOLD_TICKS out of range");
    end

    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
    localparam logic [6:0] HOLD_LAST = 7'(setpoint_pkg::HOLD_TICKS - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][31:0] sp;
        logic [1:0][31:0] target;
        logic [1:0] ramping;
        logic [1:0] ramp_arm;
        logic [1:0] pref;
        logic [1:0][1:0] range;
        logic [1:0][15:0] drive;
        logic [1:0] refused;
        logic [23:0] tick_cnt;
        logic tick;
        logic [6:0] hold_cnt;
        logic hold_done;
        logic btn_s1;
        logic btn_s2;
    } state_s;

    state_s q;
    state_s d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        logic [31:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end
        if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    function automatic logic [31:0] ramp_step(input logic [31:0] cur,
                                              input logic [31:0] tgt,
                                              input logic [9:0] rate);
        logic [31:0] step;
        logic [31:0] r;
        step = {22'h0_0000, rate};
        r = cur;
        if (tgt > cur) begin
            r = (tgt - cur <= step) ? tgt : cur + step;
        end else if (tgt < cur) begin
            r = (cur - tgt <= step) ? tgt : cur - step;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] req;
        logic [9:0] rate;
        logic allowed;
        logic hold_fire;
        logic force_off;
        logic [16:0] sum;
        logic [1:0] rv;
        lo = '0;
        hi = '0;
        req = '0;
        rate = '0;
        allowed = 1'b0;
        hold_fire = 1'b0;
        force_off = 1'b0;
        sum = '0;
        rv = '0;
        d = q;
        d.refused = '0;
        d.btn_s1 = sp_button;
        d.btn_s2 = q.btn_s1;

        // Periodic ramp update tick
        d.tick = 1'b0;
        if (q.tick_cnt == TICK_LAST) begin
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 24'h00_0001;
        end

        // Button hold timer, counted in ticks
        if (!q.btn_s2) begin
            d.hold_cnt = '0;
            d.hold_done = 1'b0;
        end else if (q.tick && !q.hold_done) begin
            if (q.hold_cnt == HOLD_LAST) begin
                hold_fire = 1'b1;
                d.hold_done = 1'b1;
            end else begin
                d.hold_cnt = q.hold_cnt + 7'h01;
            end
        end

        for (int i = 0; i < 2; i++) begin
            // Limits by control units
            if (pref_temp[i]) begin
                lo = setpoint_pkg::SP_RESET;
                hi = curve_limit[i];
            end else begin
                lo = sensor_lo[i];
                hi = sensor_hi[i];
            end
            req = clamp(setpoint_value[i], lo, hi);

            rate = (ramp_rate[i] > setpoint_pkg::RATE_MAX) ?
                setpoint_pkg::RATE_MAX : ramp_rate[i];

            // Ramp re-armed only by switching ramping off and on
            if (!ramp_en[i]) begin
                d.ramp_arm[i] = 1'b1;
            end
            if (setup_change[i] && q.ramping[i]) begin
                d.ramp_arm[i] = 1'b0;
            end
            allowed = ramp_en[i] && d.ramp_arm[i] && pref_temp[i];

            // Step toward the target on each tick
            if (q.tick && q.ramping[i]) begin
                d.sp[i] = ramp_step(q.sp[i], q.target[i], rate);
                if (d.sp[i] == q.target[i]) begin
                    d.ramping[i] = 1'b0;
                end
            end

            // Ramp shut off: keep intermediate value
            if (!allowed) begin
                d.ramping[i] = 1'b0;
                d.sp[i] = q.sp[i];
            end
            if (stop_ramp[i]) begin
                d.ramping[i] = 1'b0;
                d.sp[i] = q.sp[i];
            end

            // Setpoint entry
            if (setpoint_command[i]) begin
                if (!loop_valid[i]) begin
                    d.refused[i] = 1'b1;
                end else if (allowed) begin
                    d.target[i] = req;
                    d.sp[i] = q.sp[i];
                    d.ramping[i] = (req != q.sp[i]);
                end else begin
                    d.target[i] = req;
                    d.sp[i] = req;
                    d.ramping[i] = 1'b0;
                end
            end

            // Preferred units changed: convert through the curve
            d.pref[i] = pref_temp[i];
            if (loop_valid[i] && pref_temp[i] != q.pref[i]) begin
                d.sp[i] = conv_setpoint[i];
                d.target[i] = conv_setpoint[i];
                d.ramping[i] = 1'b0;
            end

            // Button hold: bypass ramp, load measured temperature
            if (hold_fire && disp_sel == 1'(i) && loop_valid[i]) begin
                d.sp[i] = meas_temp[i];
                d.target[i] = meas_temp[i];
                d.ramping[i] = 1'b0;
            end

            // Heater range entry
            if (range_wr[i]) begin
                rv = range_value[i];
                if (i == setpoint_pkg::VOLT_OUT && volt_mode) begin
                    rv = (range_value[i] != setpoint_pkg::RANGE_OFF) ?
                        setpoint_pkg::RANGE_ON :
                        setpoint_pkg::RANGE_OFF;
                end
                d.range[i] = rv;
            end
            if (i == setpoint_pkg::VOLT_OUT && volt_mode &&
                d.range[i] != setpoint_pkg::RANGE_OFF) begin
                d.range[i] = setpoint_pkg::RANGE_ON;
            end

            // Automatic shutdown has priority over entry
            force_off = all_off || temp_limit;
            if (setup_change[i] && q.ramping[i]) begin
                force_off = 1'b1;
            end
            if (loop_valid[i] && (setup_change[i] || power_loss_off ||
                input_error[i])) begin
                force_off = 1'b1;
            end
            if (force_off) begin
                d.range[i] = setpoint_pkg::RANGE_OFF;
            end

            // Output drive in percent of the selected range
            sum = {1'b0, pid_result[i]} + {1'b0, manual_value[i]};
            if (d.range[i] == setpoint_pkg::RANGE_OFF) begin
                d.drive[i] = '0;
            end else if (open_loop[i]) begin
                d.drive[i] = manual_value[i];
            end else if (sum > {1'b0, setpoint_pkg::PCT_MAX}) begin
                d.drive[i] = setpoint_pkg::PCT_MAX;
            end else begin
                d.drive[i] = sum[15:0];
            end
            if (manual_output_command[i] && open_loop[i] &&
                d.range[i] != setpoint_pkg::RANGE_OFF) begin
                d.drive[i] = manual_value[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All-zero reset: setpoint 0.0000 K, range Off, ramp idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign active_setpoint = q.sp;
    assign ramp_target = q.target;
    assign ramping = q.ramping;
    assign heater_range = q.range;
    assign drive = q.drive;
    assign setpoint_command_refused = q.refused;

endmodule

`default_nettype wire

// *** tb/heater_sensor_model.sv ***
// Heater stage and sensor chain model
`timescale 1ns/100ps
`default_nettype none
module heater_sensor_model #(
    parameter logic [31:0] AMBIENT = 32'h002D_C6C0,
    parameter logic [31:0] LIMIT = 32'h0035_67E0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Heater side
    input wire logic [1:0][1:0] heater_range,
    input wire logic [1:0][15:0] drive,
    input wire logic [1:0][31:0] active_setpoint,
    // Sensor side
    output logic [1:0][31:0] meas_temp,
    output logic [1:0][31:0] conv_setpoint,
    output logic temp_limit
);
    // Load heats while powered, else drifts back
    always_ff @(posedge sys_clk or negedge rst_n) begin
        for (int i = 0; i < 2; i++) begin
            if (!rst_n)
                meas_temp[i] <= AMBIENT;
            else if (heater_range[i] != 2'h0)
                meas_temp[i] <= meas_temp[i] + 32'(drive[i]);
            else if (meas_temp[i] > AMBIENT)
                meas_temp[i] <= meas_temp[i] - 32'h0000_0001;
        end
    end
    // Mirror curve, its own inverse
    always_comb begin
        for (int i = 0; i < 2; i++)
            conv_setpoint[i] = 32'h000F_4240 - active_setpoint[i];
    end
    assign temp_limit = (meas_temp[0] > LIMIT) || (meas_temp[1] > LIMIT);
endmodule
`default_nettype wire

// *** tb/setpoint_ramp_heater_range_properties.sv ***
// Port checker for the setpoint, ramp and heater range block
`timescale 1ns/100ps
`default_nettype none
module setpoint_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic [1:0] loop_valid,
    input wire logic [1:0] pref_temp,
    input wire logic volt_mode,
    input wire logic [1:0][31:0] curve_limit,
    input wire logic [1:0][31:0] sensor_lo,
    input wire logic [1:0][31:0] sensor_hi,
    input wire logic [1:0] setpoint_command,
    input wire logic [1:0][31:0] setpoint_value,
    input wire logic [1:0] stop_ramp,
    input wire logic [1:0] range_wr,
    input wire logic [1:0][1:0] range_value,
    input wire logic all_off,
    input wire logic temp_limit,
    input wire logic [1:0] setup_change,
    input wire logic [1:0] input_error,
    // Watched outputs
    input wire logic [1:0][31:0] ramp_target,
    input wire logic [1:0] ramping,
    input wire logic [1:0][1:0] heater_range,
    input wire logic [1:0][15:0] drive,
    input wire logic [1:0] setpoint_command_refused
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    refuse_entry_a: assert property (
        setpoint_command[0] |=> setpoint_command_refused[0] == !$past(loop_valid[0]))
        else $error("refusal flag wrong");
    clamp_temp_a: assert property (
        setpoint_command[0] && loop_valid[0] && pref_temp[0]
        |=> ramp_target[0] <= $past(curve_limit[0])) else $error("no clamp");
    clamp_sensor_a: assert property (
        setpoint_command[0] && loop_valid[0] && !pref_temp[0]
        |=> ramp_target[0] >= $past(sensor_lo[0])
        && ramp_target[0] <= $past(sensor_hi[0])) else $error("no clamp");
    sensor_noramp_a: assert property (
        $rose(ramping[0]) |-> $past(pref_temp[0])) else $error("ramp units");
    stop_ramp_a: assert property (
        stop_ramp[0] && !setpoint_command[0] |=> !ramping[0])
        else $error("stop ignored");
    setup_ramp_a: assert property (
        setup_change[0] && ramping[0] |=> !ramping[0]
        && heater_range[0] == 2'h0) else $error("setup change kept on");
    all_off_a: assert property (
        all_off |=> heater_range[0] == 2'h0 && heater_range[1] == 2'h0)
        else $error("all off ignored");
    temp_limit_a: assert property (
        temp_limit |=> heater_range[0] == 2'h0 && heater_range[1] == 2'h0)
        else $error("limit ignored");
    input_error_a: assert property (
        loop_valid[0] && input_error[0] |=> heater_range[0] == 2'h0)
        else $error("input error ignored");
    range_write_a: assert property (
        range_wr[1] && !all_off && !temp_limit && !loop_valid[1]
        && !(setup_change[1] && ramping[1])
        |=> heater_range[1] == (($past(volt_mode) &&
        $past(range_value[1]) != 2'h0) ? 2'h1 : $past(range_value[1])))
        else $error("range wrong");
    drive_off_a: assert property (
        heater_range[0] == 2'h0 && $past(heater_range[0]) == 2'h0
        |-> drive[0] == 16'h0000) else $error("drive while off");
endmodule
bind setpoint_ramp_heater_range setpoint_checker setpoint_checker_i (
    .sys_clk, .rst_n, .loop_valid, .pref_temp, .volt_mode, .curve_limit,
    .sensor_lo, .sensor_hi, .setpoint_command, .setpoint_value, .stop_ramp,
    .range_wr, .range_value, .all_off, .temp_limit, .setup_change,
    .input_error, .ramp_target, .ramping, .heater_range, .drive,
    .setpoint_command_refused);
`default_nettype wire

// *** tb/setpoint_ramp_heater_range_bench.sv ***
// Self-checking bench for the setpoint, ramp and heater range block
`timescale 1ns/100ps
`default_nettype none
module setpoint_ramp_heater_range_bench;
    logic sys_clk, rst_n, volt_mode, sp_button, disp_sel, all_off;
    logic power_loss_off, temp_limit;
    logic [1:0] loop_valid, pref_temp, open_loop, setpoint_command, ramp_en;
    logic [1:0] stop_ramp, range_wr, setup_change, input_error, ramping;
    logic [1:0] manual_output_command, setpoint_command_refused;
    logic [1:0][31:0] curve_limit, sensor_lo, sensor_hi, setpoint_value;
    logic [1:0][31:0] conv_setpoint, meas_temp, active_setpoint, ramp_target;
    logic [1:0][9:0] ramp_rate;
    logic [1:0][1:0] range_value, heater_range;
    logic [1:0][15:0] manual_value, pid_result, drive;
    logic [31:0] v;
    int err_count = 0;
    int check_count = 0;
    int k;
    // loop_valid, pref_temp, volt_mode, value, range, setpoint, refused, range
    int tab[6][8] = '{'{1, 1, 0, 120000, 1, 120000, 0, 1},
        '{1, 1, 0, 900000, 2, 500000, 0, 2}, '{0, 1, 0, 7, 3, 500000, 1, 3},
        '{1, 0, 0, 5, 0, 1000, 0, 0}, '{1, 0, 1, 20000, 3, 9000, 0, 1},
        '{0, 0, 1, 4000, 2, 9000, 1, 1}};

    setpoint_ramp_heater_range #(.TICK_CYCLES(20)) setpoint_ramp_heater_range_i (
        .sys_clk, .rst_n, .loop_valid, .pref_temp, .open_loop, .volt_mode,
        .curve_limit, .sensor_lo, .sensor_hi, .setpoint_command,
        .setpoint_value, .conv_setpoint, .meas_temp, .ramp_en, .ramp_rate,
        .stop_ramp, .sp_button, .disp_sel, .range_wr, .range_value, .all_off,
        .temp_limit, .setup_change, .power_loss_off, .input_error,
        .manual_output_command, .manual_value, .pid_result, .active_setpoint,
        .ramp_target, .ramping, .heater_range, .drive, .setpoint_command_refused);
    heater_sensor_model heater_sensor_model_i (.sys_clk, .rst_n,
        .heater_range, .drive, .active_setpoint, .meas_temp, .conv_setpoint,
        .temp_limit);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic final_report;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic set_sp(input logic [31:0] val);
        tick(1);
        setpoint_value[0] = val;
        setpoint_command[0] = 1'b1;
        tick(1);
        setpoint_command[0] = 1'b0;
    endtask
    task automatic set_rng(input int i, input logic [1:0] val);
        tick(1);
        range_value[i] = val;
        range_wr[i] = 1'b1;
        tick(1);
        range_wr[i] = 1'b0;
    endtask
    task automatic wait_on(input int sel, input logic [1:0] goal);
        logic [1:0] sig;
        sig = sel ? heater_range[0] : ramping;
        for (k = 0; k < 1000 && sig !== goal; k++) begin
            tick(1);
            sig = sel ? heater_range[0] : ramping;
        end
        chk(sig, goal);
        if (k == 1000)
            final_report();
    endtask

    initial begin
        {rst_n, volt_mode, sp_button, disp_sel, all_off, power_loss_off} = '0;
        {loop_valid, pref_temp, open_loop, setpoint_command, ramp_en} = '0;
        {stop_ramp, range_wr, setup_change, input_error, ramp_rate} = '0;
        {manual_output_command, range_value, pid_result} = '0;
        {sensor_lo, sensor_hi, setpoint_value} = '0;
        curve_limit = {32'h0000_0000, 32'h0007_A120};
        sensor_lo[0] = 32'h0000_03E8;
        sensor_hi[0] = 32'h0000_2328;
        ramp_rate[0] = 10'h007;
        manual_value = {16'h0100, 16'h07D0};
        open_loop[1] = 1'b1;
        tick(12);
        rst_n = 1'b1;
        chk(active_setpoint[0], 32'h0000_0000);
        chk(heater_range, 32'h0000_0000);
        manual_output_command = 2'b11;
        tick(1);
        manual_output_command = 2'b00;
        loop_valid[0] = 1'b1;
        sp_button = 1'b1;
        tick(900);
        chk(active_setpoint[0], 32'h0000_0000);
        tick(130);
        chk(active_setpoint[0], meas_temp[0]);
        chk(ramping[0], 32'h0000_0000);
        sp_button = 1'b0;
        loop_valid[0] = 1'b0;
        foreach (tab[r]) begin
            loop_valid[0] = tab[r][0][0];
            pref_temp[0] = tab[r][1][0];
            volt_mode = tab[r][2][0];
            tick(1);
            set_sp(tab[r][3]);
            chk(setpoint_command_refused[0], tab[r][6]);
            set_rng(1, tab[r][4][1:0]);
            chk(active_setpoint[0], tab[r][5]);
            chk(heater_range[1], tab[r][7]);
            tick(1);
            chk(drive[1], (tab[r][7] != 0) ? 32'h0000_0100 : 32'h0);
        end
        volt_mode = 1'b0;
        pref_temp[0] = 1'b1;
        loop_valid[0] = 1'b1;
        set_rng(1, 2'h0);
        pid_result[0] = 16'h2328;
        set_rng(0, 2'h3);
        tick(1);
        chk(drive[0], 32'h0000_2710);
        open_loop[0] = 1'b1;
        tick(2);
        chk(drive[0], 32'h0000_07D0);
        set_rng(0, 2'h0);
        set_sp(32'h0000_0064);
        ramp_en[0] = 1'b1;
        set_sp(32'h0000_007B);
        chk(ramping[0], 32'h0000_0001);
        wait_on(0, 2'b00);
        chk(active_setpoint[0], 32'h0000_007B);
        set_sp(32'h0000_0064);
        wait_on(0, 2'b00);
        chk(active_setpoint[0], 32'h0000_0064);
        set_sp(32'h0000_00C8);
        tick(50);
        stop_ramp[0] = 1'b1;
        tick(1);
        stop_ramp[0] = 1'b0;
        chk(ramping[0], 32'h0000_0000);
        chk(ramp_target[0], 32'h0000_00C8);
        tick(2);
        v = active_setpoint[0];
        tick(40);
        chk(active_setpoint[0], v);
        set_sp(32'h0000_0096);
        chk(ramping[0], 32'h0000_0001);
        tick(30);
        ramp_en[0] = 1'b0;
        tick(2);
        v = active_setpoint[0];
        tick(40);
        chk(active_setpoint[0], v);
        chk(v < 32'h0000_0096, 32'h0000_0001);
        ramp_en[0] = 1'b1;
        set_rng(0, 2'h3);
        set_sp(32'h0000_00C8);
        setup_change[0] = 1'b1;
        tick(1);
        setup_change[0] = 1'b0;
        chk({ramping[0], heater_range[0]}, 32'h0000_0000);
        set_sp(32'h0000_012C);
        chk(ramping[0], 32'h0000_0000);
        pref_temp[0] = 1'b0;
        tick(2);
        chk(active_setpoint[0], 32'h000F_4114);
        ramp_en[0] = 1'b0;
        tick(1);
        ramp_en[0] = 1'b1;
        set_sp(32'h0000_1388);
        chk(ramping[0], 32'h0000_0000);
        chk(active_setpoint[0], 32'h0000_1388);
        set_rng(0, 2'h2);
        set_rng(1, 2'h3);
        all_off = 1'b1;
        tick(1);
        all_off = 1'b0;
        chk(heater_range, 32'h0000_0000);
        set_rng(0, 2'h1);
        input_error[0] = 1'b1;
        tick(1);
        input_error[0] = 1'b0;
        chk(heater_range[0], 32'h0000_0000);
        set_rng(0, 2'h1);
        power_loss_off = 1'b1;
        tick(1);
        power_loss_off = 1'b0;
        chk(heater_range[0], 32'h0000_0000);
        set_rng(1, 2'h1);
        set_rng(0, 2'h3);
        wait_on(1, 2'h0);
        tick(1);
        chk(heater_range, 32'h0000_0000);
        rst_n = 1'b0;
        tick(2);
        chk(active_setpoint[0], 32'h0000_0000);
        rst_n = 1'b1;
        final_report();
    end
endmodule
`default_nettype wire
